/* common/irq_map_defs.svh */
// Purpose: Offsets, field positions, reset values and source masks of the interrupt map
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef IRQ_MAP_DEFS_SVH
`define IRQ_MAP_DEFS_SVH

// Register window byte addresses
`define IRQ_FLAG_BASE     12'h000
`define IRQ_ENABLE_BASE   12'h040
`define IRQ_PRIO_BASE     12'h080
`define IRQ_VSTAT_ADDR    12'h200
`define IRQ_ADDR_W        12

// Register counts and source slots
`define IRQ_FLAG_REGS     10
`define IRQ_PRIO_REGS     38
`define IRQ_SLOTS         160
`define IRQ_NUM_SRC       151
`define IRQ_FIELD_PITCH   4
`define IRQ_FIELDS_PER    4
`define IRQ_BITS_PER      16

// Vector number, table address and reset entry
`define IRQ_VECTOR_OFFSET 8'h08
`define IRQ_TABLE_BASE    24'h000004
`define IRQ_RESET_PC      24'h000000

// Status register fields
`define IRQ_VSTAT_VEC_LSB 0
`define IRQ_VSTAT_LVL_LSB 8

// Implemented sources common to all variants
`define IRQ_IMPL_BASE 160'h007e_c000_0000_0000_0000_200e_0006_0073_ff1f_7fff

// Variant-only sources, and the CRC completion source common to all variants
`define IRQ_CAN_RX        34
`define IRQ_CAN_EVENT     35
`define IRQ_CAN_TX        70
`define IRQ_PWM_SPECIAL   57
`define IRQ_QUAD_COMPARE  58
`define IRQ_PWM_GEN1      94
`define IRQ_PWM_GEN2      95
`define IRQ_PWM_GEN3      96
`define IRQ_CRC_DONE      67

`endif

/* common/irq_map_pkg.sv */
// Purpose: Types shared by the interrupt map block
// Assumes: Constants come from irq_map_defs.svh
// Notes:   No constants duplicated here
`include "irq_map_defs.svh"

package irq_map_pkg;

  // APB request from the master
  typedef struct packed {
    logic [`IRQ_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
  } apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  // Request presented to the CPU core
  typedef struct packed {
    logic        req;
    logic [7:0]  vector;
    logic [3:0]  level;
    logic [23:0] table_addr;
  } core_req_s;

  // Register window selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FLAG,
    SEL_ENABLE,
    SEL_PRIO,
    SEL_VSTAT
  } reg_sel_e;

  // Whole state of the block
  typedef struct packed {
    logic [`IRQ_SLOTS-1:0]      flags;
    logic [`IRQ_SLOTS-1:0]      enables;
    logic [`IRQ_SLOTS-1:0][2:0] prio;
    core_req_s                  core;
    logic [7:0]                 taken_vector_number;
    logic [3:0]                 taken_priority_level;
    logic [31:0]                prdata;
    logic                       rd_err;
    logic                       pc_zero;
  } state_s;

endpackage : irq_map_pkg

/* verilog/irq_vector_map.sv */
// Purpose: Reset entry and user interrupt source map with priority arbitration
// Assumes: Registers reached over APB; core acknowledges a taken request
// Notes:   Zero-wait APB slave; read data captured in the setup cycle
`timescale 1ns/10ps
`include "irq_map_defs.svh"

module irq_vector_map #(
  parameter bit HAS_CAN   = 1'b1,
  parameter bit HAS_MOTOR = 1'b1
) (
  // Clock and reset
  input  wire logic                        I_REF_CLK,
  input  wire logic                        I_RESET,
  // APB slave
  input  wire irq_map_pkg::apb_req_s       I_APB,
  output      irq_map_pkg::apb_rsp_s       O_APB,
  // Peripheral and external request events
  input  wire logic [`IRQ_NUM_SRC-1:0]     I_SRC_EVENT,
  // CPU core side
  input  wire logic [3:0]                  I_CPU_LEVEL,
  input  wire logic                        I_IRQ_ACK,
  output      irq_map_pkg::core_req_s      O_CORE,
  output      logic                        O_PC_LOAD,
  output      logic [23:0]                 O_RESET_PC
);

  // Parameter sanity: variant switches are single bits by type
  if (`IRQ_NUM_SRC > `IRQ_SLOTS) begin : g_bad_slots
    $error("irq_vector_map: more sources than register slots");
  end

  irq_map_pkg::state_s   st;
  irq_map_pkg::state_s   next_st;
  logic [`IRQ_SLOTS-1:0] impl;
  logic [`IRQ_SLOTS-1:0] events;
  logic [`IRQ_SLOTS-1:0] pending;
  irq_map_pkg::reg_sel_e sel;
  logic [5:0]            sel_idx;
  logic [31:0]           rd_word;
  logic [2:0]            best_lvl;
  logic [7:0]            best_irq;
  logic                  wr_fire;
  logic                  setup;

  // Implemented sources per variant; reserved slots stay zero
  always_comb begin
    impl = `IRQ_IMPL_BASE;
    impl[`IRQ_CAN_RX]       = HAS_CAN;
    impl[`IRQ_CAN_EVENT]    = HAS_CAN;
    impl[`IRQ_CAN_TX]       = HAS_CAN;
    impl[`IRQ_PWM_SPECIAL]  = HAS_MOTOR;
    impl[`IRQ_QUAD_COMPARE] = HAS_MOTOR;
    impl[`IRQ_PWM_GEN1]     = HAS_MOTOR;
    impl[`IRQ_PWM_GEN2]     = HAS_MOTOR;
    impl[`IRQ_PWM_GEN3]     = HAS_MOTOR;
  end

  // Pad event lines to the slot width; events on reserved slots vanish
  assign events = {{(`IRQ_SLOTS-`IRQ_NUM_SRC){1'b0}}, I_SRC_EVENT} & impl;
  assign pending = st.flags & st.enables & impl;

  // Address decode into window and register index
  always_comb begin
    sel     = irq_map_pkg::SEL_NONE;
    sel_idx = 6'h00;
    if (I_APB.paddr[1:0] == 2'h0) begin
      if (I_APB.paddr == `IRQ_VSTAT_ADDR) begin
        sel = irq_map_pkg::SEL_VSTAT;
      end else if (I_APB.paddr >= `IRQ_FLAG_BASE &&
                   I_APB.paddr < `IRQ_FLAG_BASE + 12'(4 * `IRQ_FLAG_REGS)) begin
        sel     = irq_map_pkg::SEL_FLAG;
        sel_idx = 6'((I_APB.paddr - `IRQ_FLAG_BASE) >> 2);
      end else if (I_APB.paddr >= `IRQ_ENABLE_BASE &&
                   I_APB.paddr < `IRQ_ENABLE_BASE + 12'(4 * `IRQ_FLAG_REGS)) begin
        sel     = irq_map_pkg::SEL_ENABLE;
        sel_idx = 6'((I_APB.paddr - `IRQ_ENABLE_BASE) >> 2);
      end else if (I_APB.paddr >= `IRQ_PRIO_BASE &&
                   I_APB.paddr < `IRQ_PRIO_BASE + 12'(4 * `IRQ_PRIO_REGS)) begin
        sel     = irq_map_pkg::SEL_PRIO;
        sel_idx = 6'((I_APB.paddr - `IRQ_PRIO_BASE) >> 2);
      end
    end
  end

  // Read word assembly; unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (sel)
      irq_map_pkg::SEL_FLAG: begin
        rd_word[15:0] = st.flags[sel_idx*`IRQ_BITS_PER +: `IRQ_BITS_PER];
      end
      irq_map_pkg::SEL_ENABLE: begin
        rd_word[15:0] = st.enables[sel_idx*`IRQ_BITS_PER +: `IRQ_BITS_PER];
      end
      irq_map_pkg::SEL_PRIO: begin
        for (int f = 0; f < `IRQ_FIELDS_PER; f++) begin
          rd_word[f*`IRQ_FIELD_PITCH +: 3] = st.prio[sel_idx*`IRQ_FIELDS_PER + f];
        end
      end
      irq_map_pkg::SEL_VSTAT: begin
        rd_word[`IRQ_VSTAT_VEC_LSB +: 8] = st.taken_vector_number;
        rd_word[`IRQ_VSTAT_LVL_LSB +: 4] = st.taken_priority_level;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Fixed-order scan: strict compare keeps the lower number on a tie
  always_comb begin
    best_lvl = 3'h0;
    best_irq = 8'h00;
    for (int i = 0; i < `IRQ_SLOTS; i++) begin
      if (pending[i] && st.prio[i] > best_lvl) begin
        best_lvl = st.prio[i];
        best_irq = 8'(i);
      end
    end
  end

  assign setup   = I_APB.psel && !I_APB.penable;
  assign wr_fire = I_APB.psel && I_APB.penable && I_APB.pwrite;

  // Next state
  always_comb begin
    next_st = st;
    // Setup cycle: capture read data and error so they come from flops
    if (setup) begin
      next_st.prdata = I_APB.pwrite ? 32'h0000_0000 : rd_word;
      next_st.rd_err = (sel == irq_map_pkg::SEL_NONE);
    end
    // Software writes; status register is read-only
    if (wr_fire) begin
      case (sel)
        irq_map_pkg::SEL_FLAG: begin
          next_st.flags[sel_idx*`IRQ_BITS_PER +: `IRQ_BITS_PER] = I_APB.pwdata[15:0];
        end
        irq_map_pkg::SEL_ENABLE: begin
          next_st.enables[sel_idx*`IRQ_BITS_PER +: `IRQ_BITS_PER] = I_APB.pwdata[15:0];
        end
        irq_map_pkg::SEL_PRIO: begin
          for (int f = 0; f < `IRQ_FIELDS_PER; f++) begin
            next_st.prio[sel_idx*`IRQ_FIELDS_PER + f] =
              I_APB.pwdata[f*`IRQ_FIELD_PITCH +: 3];
          end
        end
        default: begin
          next_st.flags = next_st.flags;
        end
      endcase
    end
    // Event set after the write so a same-cycle clear never loses it
    next_st.flags   = (next_st.flags | events) & impl;
    next_st.enables = next_st.enables & impl;
    for (int i = 0; i < `IRQ_SLOTS; i++) begin
      if (!impl[i]) begin
        next_st.prio[i] = 3'h0;
      end
    end
    // Registered core request; blocked during the reset entry cycle
    next_st.core.req    = !st.pc_zero && best_lvl != 3'h0 &&
                          {1'b0, best_lvl} > I_CPU_LEVEL;
    next_st.core.vector = best_irq + `IRQ_VECTOR_OFFSET;
    next_st.core.level  = {1'b0, best_lvl};
    next_st.core.table_addr = `IRQ_TABLE_BASE + {15'h0000, best_irq + `IRQ_VECTOR_OFFSET, 1'b0};
    // Latch what the core took
    if (I_IRQ_ACK && st.core.req) begin
      next_st.taken_vector_number  = st.core.vector;
      next_st.taken_priority_level = st.core.level;
    end
    next_st.pc_zero = 1'b0;
  end

  // State register; reset clears everything and forces the PC
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      st         <= '0;
      st.pc_zero <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign O_APB.prdata  = st.prdata;
  assign O_APB.pready  = 1'b1;
  assign O_APB.pslverr = I_APB.psel && I_APB.penable && st.rd_err;
  assign O_CORE        = st.core;
  assign O_PC_LOAD     = st.pc_zero;
  assign O_RESET_PC    = `IRQ_RESET_PC;

  // Checks
  a_reset_pc_force: assert property (@(posedge I_REF_CLK)
    I_RESET |=> O_PC_LOAD && !O_CORE.req && st.flags == '0)
    else $error("reset did not force PC load with a quiet controller");

  a_release_fetch: assert property (@(posedge I_REF_CLK)
    $fell(I_RESET) |-> O_PC_LOAD ##1 !O_PC_LOAD && O_RESET_PC == 24'h000000)
    else $error("fetch did not start from address zero after release");

  a_vector_number: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_CORE.req |-> O_CORE.vector >= 8'h08 && pending[O_CORE.vector - 8'h08]
      || $past(pending[O_CORE.vector - 8'h08]))
    else $error("request vector does not map back to a pending source");

  a_table_addr: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_CORE.req |-> O_CORE.table_addr == 24'h000004 + {15'h0000, O_CORE.vector, 1'b0})
    else $error("table address is not four plus twice the vector");

  a_reserved_quiet: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (st.flags & ~impl) == '0 && (st.enables & ~impl) == '0)
    else $error("reserved source holds a flag or enable bit");

  a_flag_sticky: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    events[3] |=> st.flags[3])
    else $error("source event did not set its flag");

  a_flag_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    st.flags[3] && !wr_fire |=> st.flags[3])
    else $error("flag cleared without a software write");

  a_crc_slot: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    I_SRC_EVENT[`IRQ_CRC_DONE] |=> st.flags[4*16+3])
    else $error("CRC event did not set flag register 4 bit 3");

  a_take_latch: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    I_IRQ_ACK && O_CORE.req |=> st.taken_vector_number == $past(O_CORE.vector)
      && st.taken_priority_level == $past(O_CORE.level))
    else $error("taken vector or level not latched");

  a_level_above: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_CORE.req |-> O_CORE.level != 4'h0 && O_CORE.level > $past(I_CPU_LEVEL))
    else $error("request raised at or below the CPU level");

  // Slots above the last source must stay empty whatever software writes
  a_upper_reserved: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    st.flags[`IRQ_SLOTS-1:`IRQ_NUM_SRC] == '0
      && st.enables[`IRQ_SLOTS-1:`IRQ_NUM_SRC] == '0)
    else $error("slot above the highest source holds a flag or enable bit");

  // Reserved priority fields drop written values
  a_reserved_prio: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    st.prio[15] == 3'h0 && st.prio[21] == 3'h0)
    else $error("reserved source holds a priority value");

  // Status moves only when the core takes a raised request
  a_status_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    !(I_IRQ_ACK && O_CORE.req) |=> $stable(st.taken_vector_number)
      && $stable(st.taken_priority_level))
    else $error("vector status changed without a taken request");

endmodule : irq_vector_map

/* verif/cpu_core_model.sv */
// Purpose: CPU core stand-in that takes interrupt requests
// Assumes: One ack pulse per raised request, prompt or slow
// Notes:   Slow mode waits three cycles, as a busy core would
`timescale 1ns/10ps

module cpu_core_model (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // Request side
  input  wire irq_map_pkg::core_req_s i_core,
  input  wire logic                   i_slow,
  output      logic                   o_ack
);
  logic [1:0] wait_cnt;
  logic       taken;

  // Ack once per request; a held request is not acked again
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_core.req) begin
      wait_cnt <= 2'h0;
      taken    <= 1'b0;
      o_ack    <= 1'b0;
    end else if (!taken && (!i_slow || wait_cnt == 2'h3)) begin
      o_ack <= 1'b1;
      taken <= 1'b1;
    end else begin
      o_ack    <= 1'b0;
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : cpu_core_model

/* verif/irq_vector_map_tb_top.sv */
// Purpose: Self-checking bench for the interrupt source map
// Assumes: Zero-wait APB slave, core model acks requests
// Notes:   Expected APB results are queued and checked by a monitor
`timescale 1ns/10ps
`include "irq_map_defs.svh"

module irq_vector_map_tb_top;
  logic                     ref_clk = 1'b0;
  logic                     reset   = 1'b1;
  irq_map_pkg::apb_req_s    apb     = '0;
  irq_map_pkg::apb_rsp_s    apb_rsp;
  logic [`IRQ_NUM_SRC-1:0]  src_event = '0;
  logic [3:0]               cpu_level = 4'h0;
  logic                     irq_ack;
  logic                     slow    = 1'b0;
  irq_map_pkg::core_req_s   core;
  logic                     pc_load;
  logic [23:0]              reset_pc;
  logic [33:0]              exp_q[$];
  logic [33:0]              e;
  integer                   n_errors = 0;
  integer                   samples_checked = 0;
  integer                   seed = 96446;
  logic [2:0]               p;

  irq_vector_map irq_vector_map_i (.I_REF_CLK(ref_clk), .I_RESET(reset), .I_APB(apb),
    .O_APB(apb_rsp), .I_SRC_EVENT(src_event), .I_CPU_LEVEL(cpu_level),
    .I_IRQ_ACK(irq_ack), .O_CORE(core), .O_PC_LOAD(pc_load), .O_RESET_PC(reset_pc));

  cpu_core_model cpu_core_model_i (.i_clk(ref_clk), .i_reset(reset), .i_core(core),
    .i_slow(slow), .o_ack(irq_ack));

  // Free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // One APB transfer; the expected answer is queued for the monitor
  task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                input logic err, input logic [31:0] rd);
    @(posedge ref_clk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.paddr <= a;
    apb.pwrite <= w;
    apb.pwdata <= d;
    exp_q.push_back({w, err, rd});
    @(posedge ref_clk);
    apb.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_xfer

  // Pulse a set of source events for one cycle
  task pulse(input logic [`IRQ_NUM_SRC-1:0] ev);
    @(posedge ref_clk);
    src_event <= ev;
    @(posedge ref_clk);
    src_event <= '0;
  endtask : pulse

  // Bounded wait for the core request to reach a level
  task wait_req(input logic v);
    integer k;
    k = 0;
    #1;
    while (core.req !== v && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check("core_req", {31'h0, core.req}, {31'h0, v});
  endtask : wait_req

  // Monitor: oldest note is compared when an access completes
  always @(posedge ref_clk) begin
    if (apb.psel && apb.penable && apb_rsp.pready) begin
      e = exp_q.pop_front();
      check("pslverr", {31'h0, apb_rsp.pslverr}, {31'h0, e[32]});
      if (!e[33]) check("prdata", apb_rsp.prdata, e[31:0]);
    end
  end

  // Hang guard, far above the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    check("pc_load", {31'h0, pc_load}, 32'h1);
    check("reset_pc", {8'h0, reset_pc}, 32'h0);
    check("core_req", {31'h0, core.req}, 32'h0);
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("pc_load", {31'h0, pc_load}, 32'h0);
    $display("test reset done");
    // Reserved slot and unmapped address
    apb_xfer(1'b1, `IRQ_ENABLE_BASE, 32'hffff_ffff, 1'b0, 32'h0);
    apb_xfer(1'b0, `IRQ_ENABLE_BASE, 32'h0, 1'b0, 32'h0000_7fff);
    apb_xfer(1'b1, `IRQ_PRIO_BASE + 12'h00c, 32'h0000_7777, 1'b0, 32'h0);
    apb_xfer(1'b0, `IRQ_PRIO_BASE + 12'h00c, 32'h0, 1'b0, 32'h0000_0777);
    pulse(151'h1 << 15);
    apb_xfer(1'b0, `IRQ_FLAG_BASE, 32'h0, 1'b0, 32'h0);
    #1;
    check("reserved_req", {31'h0, core.req}, 32'h0);
    apb_xfer(1'b0, 12'h3fc, 32'h0, 1'b1, 32'h0);
    // Variant and upper slots keep only implemented enable bits
    apb_xfer(1'b1, `IRQ_ENABLE_BASE + 12'h008, 32'hffff_ffff, 1'b0, 32'h0);
    apb_xfer(1'b0, `IRQ_ENABLE_BASE + 12'h008, 32'h0, 1'b0, 32'h0000_007f);
    apb_xfer(1'b1, `IRQ_ENABLE_BASE + 12'h00c, 32'hffff_ffff, 1'b0, 32'h0);
    apb_xfer(1'b0, `IRQ_ENABLE_BASE + 12'h00c, 32'h0, 1'b0, 32'h0000_0606);
    apb_xfer(1'b1, `IRQ_ENABLE_BASE + 12'h024, 32'hffff_ffff, 1'b0, 32'h0);
    apb_xfer(1'b0, `IRQ_ENABLE_BASE + 12'h024, 32'h0, 1'b0, 32'h0000_007e);
    apb_xfer(1'b1, `IRQ_ENABLE_BASE, 32'h0, 1'b0, 32'h0);
    $display("test reserved done");
    // Completion source with random nonzero priority
    p = 3'({$random(seed)} % 7 + 1);
    apb_xfer(1'b1, `IRQ_PRIO_BASE + 12'h040, {17'h0, p, 12'h0}, 1'b0, 32'h0);
    apb_xfer(1'b1, `IRQ_ENABLE_BASE + 12'h010, 32'h8, 1'b0, 32'h0);
    pulse(151'h1 << 67);
    apb_xfer(1'b0, `IRQ_FLAG_BASE + 12'h010, 32'h0, 1'b0, 32'h8);
    wait_req(1'b1);
    check("vector", {24'h0, core.vector}, 32'd75);
    check("level", {28'h0, core.level}, {29'h0, p});
    check("table", {8'h0, core.table_addr}, 32'h0000_009a);
    repeat (3) @(posedge ref_clk);
    apb_xfer(1'b0, `IRQ_VSTAT_ADDR, 32'h0, 1'b0, {21'h0, p, 8'h4b});
    $display("test completion done");
    // CPU level at the source priority masks it
    cpu_level <= {1'b0, p};
    repeat (3) @(posedge ref_clk);
    #1;
    check("masked", {31'h0, core.req}, 32'h0);
    @(posedge ref_clk);
    cpu_level <= 4'h0;
    // Software clear drops the request
    apb_xfer(1'b1, `IRQ_FLAG_BASE + 12'h010, 32'h0, 1'b0, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    check("cleared", {31'h0, core.req}, 32'h0);
    $display("test mask done");
    // Equal priority tie, slow core
    @(posedge ref_clk);
    slow <= 1'b1;
    apb_xfer(1'b1, `IRQ_PRIO_BASE, {17'h0, p, 5'h0, p, 4'h0}, 1'b0, 32'h0);
    apb_xfer(1'b1, `IRQ_ENABLE_BASE, 32'ha, 1'b0, 32'h0);
    pulse(151'ha);
    wait_req(1'b1);
    check("tie", {24'h0, core.vector}, 32'd9);
    apb_xfer(1'b1, `IRQ_FLAG_BASE, 32'h8, 1'b0, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    check("next", {24'h0, core.vector}, 32'd11);
    $display("test tie done");
    test_done();
  end
endmodule : irq_vector_map_tb_top
